// ==== itb_pkg.sv ====
// Purpose: shared constants and types of the 10-bit target address block
// Assumes: one 10 MHz module clock, asynchronous active-high reset
// Notes: clock-rate rows live in the rate lookup module
package itb_pkg;
   // fixed upper five bits of a 10-bit first address byte
   localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
   // bit count at which the eighth data bit has been shifted in
   localparam logic [3:0] ACK_BIT_CNT = 4'h8;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;
   // widths of the divider and hold counts
   localparam int DIV_W = 12;
   localparam int SDA_HOLD_W = 10;
   localparam int START_HOLD_W = 11;
   localparam int ROW_W = DIV_W + SDA_HOLD_W + START_HOLD_W;
   // values after reset, and the divider count step
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [DIV_W-1:0] DIV_CNT_RST = 12'h000;
   localparam logic [DIV_W-1:0] DIV_CNT_ONE = 12'h001;
   // target-side protocol states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR1,
      ST_ADDR2,
      ST_RX,
      ST_TX,
      ST_SKIP
   } itb_state_t;
endpackage : itb_pkg

// ==== itb_rate_rom.sv ====
// Purpose: maps the clock-rate code to SCL divider and hold counts
// Assumes: code changes are rare; one cycle of latency is harmless
// Notes: codes outside the held rows fall back to the slowest row
`timescale 1ns/1ps
module itb_rate_rom
   import itb_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic [5:0] clock_rate_code_in,
   output logic [DIV_W-1:0] div_out,
   output logic [SDA_HOLD_W-1:0] sda_hold_out,
   output logic [START_HOLD_W-1:0] start_hold_out
);
   ////////////////////////////////////////////////////////////////////////////
   // lookup: {scl divider, sda hold, start scl hold} in module clocks
   function automatic logic [ROW_W-1:0] rate_row(input logic [5:0] code);
      case (code)
         6'h15: rate_row = {12'h058, 10'h011, 11'h026};
         6'h16: rate_row = {12'h068, 10'h015, 11'h02E};
         6'h17: rate_row = {12'h080, 10'h015, 11'h03A};
         6'h18: rate_row = {12'h050, 10'h009, 11'h026};
         6'h19: rate_row = {12'h060, 10'h009, 11'h02E};
         6'h1A: rate_row = {12'h070, 10'h011, 11'h036};
         6'h1B: rate_row = {12'h080, 10'h011, 11'h03E};
         6'h1C: rate_row = {12'h090, 10'h019, 11'h046};
         6'h1D: rate_row = {12'h0A0, 10'h019, 11'h04E};
         6'h1E: rate_row = {12'h0C0, 10'h021, 11'h05E};
         6'h1F: rate_row = {12'h0F0, 10'h021, 11'h076};
         6'h35: rate_row = {12'h500, 10'h0C1, 11'h27E};
         6'h36: rate_row = {12'h600, 10'h101, 11'h2FE};
         6'h37: rate_row = {12'h780, 10'h101, 11'h3BE};
         6'h38: rate_row = {12'h500, 10'h081, 11'h27E};
         6'h39: rate_row = {12'h600, 10'h081, 11'h2FE};
         6'h3A: rate_row = {12'h700, 10'h101, 11'h37E};
         6'h3B: rate_row = {12'h800, 10'h101, 11'h3FE};
         6'h3C: rate_row = {12'h900, 10'h181, 11'h47E};
         6'h3D: rate_row = {12'hA00, 10'h181, 11'h4FE};
         6'h3E: rate_row = {12'hC00, 10'h201, 11'h5FE};
         // slowest row for the rest: never faster than asked
         default: rate_row = {12'hF00, 10'h201, 11'h77E};
      endcase
   endfunction : rate_row

   wire logic [ROW_W-1:0] row_w = rate_row(clock_rate_code_in);

   // registered read so the divider sees a clean value
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         div_out <= '0;
         sda_hold_out <= '0;
         start_hold_out <= '0;
      end else begin
         {div_out, sda_hold_out, start_hold_out} <= row_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   property p_code_15;
      @(posedge clk_sys_in) disable iff (rst_in)
      clock_rate_code_in == 6'h15 |=> div_out == 12'h058 && sda_hold_out == 10'h011 && start_hold_out == 11'h026;
   endproperty
   a_code_15: assert property (p_code_15) else $error("code 15 row wrong");
   property p_code_17;
      @(posedge clk_sys_in) disable iff (rst_in)
      clock_rate_code_in == 6'h17 |=> div_out == 12'h080 && sda_hold_out == 10'h015 && start_hold_out == 11'h03A;
   endproperty
   a_code_17: assert property (p_code_17) else $error("code 17 row wrong");
   property p_code_1f;
      @(posedge clk_sys_in) disable iff (rst_in)
      clock_rate_code_in == 6'h1F |=> div_out == 12'h0F0 && sda_hold_out == 10'h021 && start_hold_out == 11'h076;
   endproperty
   a_code_1f: assert property (p_code_1f) else $error("code 1f row wrong");
   property p_code_3b;
      @(posedge clk_sys_in) disable iff (rst_in)
      clock_rate_code_in == 6'h3B |=> div_out == 12'h800 && sda_hold_out == 10'h101 && start_hold_out == 11'h3FE;
   endproperty
   a_code_3b: assert property (p_code_3b) else $error("code 3b row wrong");
   property p_code_3f;
      @(posedge clk_sys_in) disable iff (rst_in)
      clock_rate_code_in == 6'h3F |=> div_out == 12'hF00 && sda_hold_out == 10'h201 && start_hold_out == 11'h77E;
   endproperty
   a_code_3f: assert property (p_code_3f) else $error("code 3f row wrong");
endmodule : itb_rate_rom

// ==== itb_target.sv ====
// Purpose: two-wire target with 10-bit address recognition and rate divider
// Assumes: scl and sda inputs already synchronous to clk_sys_in
// Notes: sda is open drain; the pad pulls low while sda_oe_out is high
// Function
// - a 10-bit first address byte starts with the fixed prefix 11110
// - after start, match prefix plus two high bits with direction 0, then acknowledge
// - second byte must equal the low eight address bits to be acknowledged
// - matched receiver stays selected until stop or restart with another address
// - first address byte raises the transfer event; its data is not payload
// - master reads via start, both bytes written, restart, then direction flips
// - remembered match plus same first byte with direction 1 selects transmitter
// - transmitter stays selected until stop or restart with another address
// - unmatched device ignores prefix read; 7-bit match never takes the prefix
// - rate code 17 gives divider 128, sda hold 21, start hold 58
// - rate code 1F gives divider 240, sda hold 33, start hold 118
// - rate code 3B gives divider 2048, sda hold 257, start hold 1022
// - rate code 3F gives divider 3840, sda hold 513, start hold 1918
// - extended address bits join matching only when extension is enabled
// - a second-byte match enters receiver operation and sets the addressed flag
`timescale 1ns/1ps
module itb_target
   import itb_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic module_enable_in,
   input wire logic address_extension_enable_in,
   input wire logic [6:0] own_addr_in,
   input wire logic target_addr_bit_ten_in,
   input wire logic target_addr_bit_nine_in,
   input wire logic target_addr_bit_eight_in,
   input wire logic [5:0] clock_rate_code_in,
   input wire logic [7:0] tx_data_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic addressed_as_target_flag_out,
   output logic transmit_mode_out,
   output logic byte_done_out,
   output logic [7:0] rx_data_out,
   output logic rx_data_valid_out,
   output logic scl_gen_out,
   output logic sda_hold_tick_out,
   output logic start_hold_tick_out
);
   ////////////////////////////////////////////////////////////////////////////
   // state; every check runs on the module clock and rests while reset is high
   itb_state_t state_ff;
   itb_state_t nxt_state;
   logic scl_q_ff;
   logic sda_q_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_shift_ff;
   logic in_ack_ff;
   logic nack_ff;
   logic matched_ff;
   logic nxt_matched;
   logic nxt_aat;
   logic nxt_oe;
   logic [DIV_W-1:0] div_cnt_ff;
   wire logic [DIV_W-1:0] div_w;
   wire logic [SDA_HOLD_W-1:0] sda_hold_w;
   wire logic [START_HOLD_W-1:0] start_hold_w;
   default clocking cb_sys @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   ////////////////////////////////////////////////////////////////////////////
   // bus condition decode from the previous sample
   wire logic scl_rise = scl_in & ~scl_q_ff;
   wire logic scl_fall = ~scl_in & scl_q_ff;
   wire logic start_det = scl_in & scl_q_ff & sda_q_ff & ~sda_in;
   wire logic stop_det = scl_in & scl_q_ff & ~sda_q_ff & sda_in;
   wire logic byte_end = scl_fall & (bit_cnt_ff == ACK_BIT_CNT) & ~in_ack_ff;
   wire logic ack_fall = scl_fall & in_ack_ff;
   wire logic tx_fall = scl_fall & ~in_ack_ff & (state_ff == ST_TX) & ~nack_ff;

   // address compares
   wire logic ext_en = address_extension_enable_in;
   wire logic rw_bit = shift_ff[0];
   wire logic [6:0] hi7_w = {TEN_BIT_PREFIX, target_addr_bit_ten_in, target_addr_bit_nine_in};
   wire logic [7:0] lo8_w = {target_addr_bit_eight_in, own_addr_in};
   wire logic hi_match = ext_en & (shift_ff[7:1] == hi7_w);
   wire logic own_is_prefix = (own_addr_in[6:2] == TEN_BIT_PREFIX);
   // a 7-bit device never claims the reserved prefix
   wire logic seven_match = ~ext_en & (shift_ff[7:1] == own_addr_in) & ~own_is_prefix;
   wire logic lo_match = (shift_ff == lo8_w);
   wire logic ack_a1 = hi_match & ~rw_bit;
   // a read after restart needs the remembered match
   wire logic ack_a3 = hi_match & rw_bit & matched_ff;
   wire logic addr1_ack = ack_a1 | ack_a3 | seven_match;
   wire logic ack_now = ((state_ff == ST_ADDR1) & addr1_ack) | ((state_ff == ST_ADDR2) & lo_match)
                        | (state_ff == ST_RX);
   wire logic sel_next = (nxt_state == ST_RX) | (nxt_state == ST_TX);
   wire logic addr_next = (nxt_state == ST_ADDR1) | (nxt_state == ST_ADDR2);

   ////////////////////////////////////////////////////////////////////////////
   // protocol sequencing
   always_comb begin
      nxt_state = state_ff;
      if (!module_enable_in) begin
         nxt_state = ST_IDLE;
      end else if (start_det) begin
         nxt_state = ST_ADDR1;
      end else if (stop_det) begin
         nxt_state = ST_IDLE;
      end else if (byte_end) begin
         unique case (state_ff)
            ST_ADDR1: begin
               if (ack_a1) begin
                  nxt_state = ST_ADDR2;
               end else if (ack_a3) begin
                  nxt_state = ST_TX;
               end else if (seven_match) begin
                  nxt_state = rw_bit ? ST_TX : ST_RX;
               end else begin
                  nxt_state = ST_SKIP;
               end
            end
            ST_ADDR2: nxt_state = lo_match ? ST_RX : ST_SKIP;
            ST_RX: nxt_state = ST_RX;
            ST_TX: nxt_state = ST_TX;
            ST_IDLE: nxt_state = ST_IDLE;
            ST_SKIP: nxt_state = ST_SKIP;
         endcase
      end
   end

   // remembered 10-bit match across a restart
   always_comb begin
      nxt_matched = matched_ff;
      if (!module_enable_in || stop_det) begin
         nxt_matched = 1'b0;
      end else if (byte_end && state_ff == ST_ADDR1) begin
         nxt_matched = matched_ff & (ack_a1 | ack_a3);
      end else if (byte_end && state_ff == ST_ADDR2) begin
         nxt_matched = lo_match;
      end
   end

   // selected while in data phase, held through a restart until it fails
   assign nxt_aat = sel_next | (addressed_as_target_flag_out & addr_next);
   // open-drain drive: address or data ack, then transmit bits
   always_comb begin
      nxt_oe = sda_oe_out;
      if (!module_enable_in || start_det || stop_det) begin
         nxt_oe = 1'b0;
      end else if (byte_end) begin
         nxt_oe = (state_ff != ST_TX) & ack_now;
      end else if (ack_fall) begin
         nxt_oe = (state_ff == ST_TX) & ~nack_ff & ~tx_data_in[7];
      end else if (tx_fall) begin
         nxt_oe = ~tx_shift_ff[6];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin samples and state registers
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         state_ff <= ST_IDLE;
         matched_ff <= 1'b0;
         sda_oe_out <= 1'b0;
         sda_out <= 1'b0;
         addressed_as_target_flag_out <= 1'b0;
         transmit_mode_out <= 1'b0;
      end else begin
         scl_q_ff <= scl_in;
         sda_q_ff <= sda_in;
         state_ff <= nxt_state;
         matched_ff <= nxt_matched;
         sda_oe_out <= nxt_oe;
         sda_out <= 1'b0;
         addressed_as_target_flag_out <= nxt_aat;
         transmit_mode_out <= (nxt_state == ST_TX);
      end
   end

   // bit counter and receive shifter; the ninth clock wraps the count
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         bit_cnt_ff <= BIT_CNT_RST;
         shift_ff <= BYTE_RST;
      end else if (start_det || stop_det || !module_enable_in) begin
         bit_cnt_ff <= BIT_CNT_RST;
      end else if (scl_rise) begin
         bit_cnt_ff <= (bit_cnt_ff == ACK_BIT_CNT) ? BIT_CNT_RST : bit_cnt_ff + 4'h1;
         if (bit_cnt_ff != ACK_BIT_CNT) begin
            shift_ff <= {shift_ff[6:0], sda_in};
         end
      end
   end

   // ack window and master ack seen while transmitting
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         in_ack_ff <= 1'b0;
         nack_ff <= 1'b0;
      end else if (start_det || stop_det || !module_enable_in) begin
         in_ack_ff <= 1'b0;
         nack_ff <= 1'b0;
      end else begin
         if (byte_end) begin
            in_ack_ff <= 1'b1;
         end else if (scl_fall) begin
            in_ack_ff <= 1'b0;
         end
         // a master nack stops the drive until the next start or stop
         if (scl_rise && in_ack_ff && state_ff == ST_TX) begin
            nack_ff <= sda_in;
         end
      end
   end

   // transmit shifter, loaded as the ack clock ends
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         tx_shift_ff <= BYTE_RST;
      end else if (ack_fall) begin
         tx_shift_ff <= tx_data_in;
      end else if (tx_fall) begin
         tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
      end
   end

   // byte event; address bytes carry no valid payload
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         byte_done_out <= 1'b0;
         rx_data_out <= BYTE_RST;
         rx_data_valid_out <= 1'b0;
      end else begin
         byte_done_out <= byte_end & (ack_now | (state_ff == ST_TX)) & module_enable_in;
         if (byte_end && ack_now) begin
            rx_data_out <= shift_ff;
            rx_data_valid_out <= (state_ff == ST_RX);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // rate divider: low half then high half, holds counted from scl fall
   itb_rate_rom itb_rate_rom_inst (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .clock_rate_code_in(clock_rate_code_in),
      .div_out(div_w),
      .sda_hold_out(sda_hold_w),
      .start_hold_out(start_hold_w)
   );
   wire logic [DIV_W-1:0] div_half_w = div_w >> 1;
   // a code change mid-period ends that period early rather than overrunning
   wire logic [DIV_W-1:0] nxt_div_cnt = (div_cnt_ff >= div_w - DIV_CNT_ONE) ? DIV_CNT_RST
                                        : div_cnt_ff + DIV_CNT_ONE;
   wire logic [DIV_W-1:0] sda_hold_ext = {2'h0, sda_hold_w};
   wire logic [DIV_W-1:0] start_hold_ext = {1'h0, start_hold_w};
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         div_cnt_ff <= DIV_CNT_RST;
         scl_gen_out <= 1'b1;
         sda_hold_tick_out <= 1'b0;
         start_hold_tick_out <= 1'b0;
      end else if (!module_enable_in) begin
         div_cnt_ff <= DIV_CNT_RST;
         scl_gen_out <= 1'b1;
         sda_hold_tick_out <= 1'b0;
         start_hold_tick_out <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         scl_gen_out <= (nxt_div_cnt >= div_half_w);
         sda_hold_tick_out <= (nxt_div_cnt == sda_hold_ext);
         start_hold_tick_out <= (nxt_div_cnt == start_hold_ext);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_addr1_end;
      byte_end && state_ff == ST_ADDR1 && module_enable_in && !start_det && !stop_det;
   endsequence
   sequence s_addr2_end;
      byte_end && state_ff == ST_ADDR2 && module_enable_in && !start_det && !stop_det;
   endsequence
   property p_prefix_only;
      s_addr1_end and (ext_en && shift_ff[7:3] != TEN_BIT_PREFIX) |=> !sda_oe_out && state_ff == ST_SKIP;
   endproperty
   a_prefix_only: assert property (p_prefix_only) else $error("non-prefix byte accepted");
   property p_first_ack;
      s_addr1_end and (ack_a1) |=> sda_oe_out && state_ff == ST_ADDR2;
   endproperty
   a_first_ack: assert property (p_first_ack) else $error("first address byte not acked");
   property p_second_byte;
      s_addr2_end |=> sda_oe_out == $past(lo_match) && matched_ff == $past(lo_match);
   endproperty
   a_second_byte: assert property (p_second_byte) else $error("second byte ack wrong");
   property p_rx_hold;
      state_ff == ST_RX && module_enable_in && !start_det && !stop_det
         |=> state_ff == ST_RX && addressed_as_target_flag_out;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("receiver lost selection");
   property p_first_event;
      s_addr1_end and (ack_a1) |=> byte_done_out && !rx_data_valid_out;
   endproperty
   a_first_event: assert property (p_first_event) else $error("address byte event wrong");
   property p_readdress;
      s_addr1_end and (ack_a3) |=> transmit_mode_out ##0 sda_oe_out;
   endproperty
   a_readdress: assert property (p_readdress) else $error("restart read not selected");
   property p_tx_hold;
      transmit_mode_out && module_enable_in && !start_det && !stop_det |=> transmit_mode_out;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("transmitter lost selection");
   property p_no_blind_read;
      s_addr1_end and (ext_en && rw_bit && !matched_ff) |=> !sda_oe_out && !transmit_mode_out;
   endproperty
   a_no_blind_read: assert property (p_no_blind_read) else $error("unmatched read acked");
   property p_ext_off;
      s_addr1_end and (!ext_en) |=> state_ff != ST_ADDR2;
   endproperty
   a_ext_off: assert property (p_ext_off) else $error("extension used while off");
   property p_match_flag;
      s_addr2_end and (lo_match) |=> addressed_as_target_flag_out && state_ff == ST_RX;
   endproperty
   a_match_flag: assert property (p_match_flag) else $error("addressed flag not set");
   property p_scl_phase;
      $rose(scl_gen_out) && module_enable_in |-> div_cnt_ff == div_half_w ##1 !$fell(scl_gen_out);
   endproperty
   a_scl_phase: assert property (p_scl_phase) else $error("scl phase off count");
   property p_forget;
      (stop_det || !module_enable_in) |=> !matched_ff ##1 !matched_ff || $past(byte_end);
   endproperty
   a_forget: assert property (p_forget) else $error("remembered match not cleared");
endmodule : itb_target

// ==== itb_master.sv ====
// Purpose: behavioural bus master that drives scl and sda
// Assumes: target never stretches scl; sda has a pull-up
// Notes: a third of a bit is four module clocks; released sda reads high
`timescale 1ns/1ps
module itb_master (
   input wire logic clk_sys_in,
   input wire logic sda_bus_in,
   output logic scl_out,
   output logic sda_out
);
   // bus idles high until the first frame
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   ////////////////////////////////////////////////////////////////
   // lines change just after an edge, so sampling never races
   task automatic half();
      repeat (4) @(posedge clk_sys_in);
      #1;
   endtask : half
   // works from idle and, as repeated start, from mid-frame
   task automatic start();
      sda_out = 1'b1;
      half();
      scl_out = 1'b1;
      half();
      sda_out = 1'b0;
      half();
      scl_out = 1'b0;
      half();
   endtask : start
   task automatic stop();
      sda_out = 1'b0;
      half();
      scl_out = 1'b1;
      half();
      sda_out = 1'b1;
      half();
   endtask : stop
   // eight bits msb first, then the ack slot; mack drives our own ack
   task automatic xfer(input logic [7:0] b, input logic mack, output logic ack, output logic [7:0] rd);
      for (int i = 7; i >= 0; i--) begin
         sda_out = b[i];
         half();
         scl_out = 1'b1;
         half();
         rd[i] = sda_bus_in;
         scl_out = 1'b0;
         half();
      end
      sda_out = ~mack;
      half();
      scl_out = 1'b1;
      half();
      ack = ~sda_bus_in;
      scl_out = 1'b0;
      half();
   endtask : xfer
endmodule : itb_master

// ==== test_itb_target.sv ====
// Purpose: self-checking bench for the 10-bit target and rate divider
// Assumes: one master model on the bus, pull-up on sda
// Notes: divider measured on scl_gen and the two hold ticks
`timescale 1ns/1ps
module test_itb_target;
   import itb_pkg::*;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic en = 1'b0;
   logic ext = 1'b1;
   logic [6:0] own = 7'h2A;
   logic [5:0] code = 6'h15;
   logic [7:0] r;
   logic a;
   wire logic scl, sda_m, oe, flag, txm, rxv, sclg, sht, stt, bd;
   wire logic [7:0] rxd;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   int dones = 0;
   // open drain: whoever pulls low wins
   wire logic sda_bus = sda_m & ~oe;
   itb_master itb_master_inst (.clk_sys_in(clk_sys_in), .sda_bus_in(sda_bus), .scl_out(scl), .sda_out(sda_m));
   itb_target itb_target_inst (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .module_enable_in(en),
      .address_extension_enable_in(ext), .own_addr_in(own), .target_addr_bit_ten_in(1'b1),
      .target_addr_bit_nine_in(1'b0), .target_addr_bit_eight_in(1'b1), .clock_rate_code_in(code),
      .tx_data_in(8'hC3), .scl_in(scl), .sda_in(sda_bus), .sda_out(), .sda_oe_out(oe),
      .addressed_as_target_flag_out(flag), .transmit_mode_out(txm), .byte_done_out(bd),
      .rx_data_out(rxd), .rx_data_valid_out(rxv), .scl_gen_out(sclg), .sda_hold_tick_out(sht),
      .start_hold_tick_out(stt));
   always #50 clk_sys_in = ~clk_sys_in;
   // byte events counted mid-cycle, away from the edge that launches them
   always @(negedge clk_sys_in) begin
      if (bd === 1'b1) begin
         dones++;
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize
   // a hang counts as a mismatch and still reaches the report
   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         summarize();
      end
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] b, input logic e);
      itb_master_inst.xfer(b, 1'b0, a, r);
      chk({11'h000, a}, {11'h000, e});
   endtask : wr
   // cycles from one scl_gen fall to the next, ticks counted from the fall
   task automatic fall(output logic [11:0] n, output logic [11:0] ns, output logic [11:0] nh);
      logic p;
      n = 12'h000;
      ns = 12'h000;
      nh = 12'h000;
      do begin
         p = sclg;
         @(posedge clk_sys_in);
         #1;
         n++;
         if (sht) ns = n;
         if (stt) nh = n;
      end while (!(p && !sclg));
   endtask : fall
   // first two falls may belong to the old code, so they are dropped
   task automatic rate(input logic [5:0] c, input logic [11:0] d, input logic [11:0] s, input logic [11:0] h);
      logic [11:0] n, ns, nh;
      code = c;
      fall(n, ns, nh);
      fall(n, ns, nh);
      fall(n, ns, nh);
      chk(n, d);
      chk(ns, s);
      chk(nh, h);
   endtask : rate
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk_sys_in);
      #1;
      rst_in = 1'b0;
      en = 1'b1;
      chk(sclg, 1'b1);
      chk(flag, 1'b0);
      repeat (2) @(posedge clk_sys_in);
      #1;
      // write, restart as reader, stop, then an unremembered read
      itb_master_inst.start();
      wr(8'hF4, 1'b1);
      chk(rxd, 8'hF4);
      chk(rxv, 1'b0);
      chk(dones[11:0], 12'h001);
      wr(8'hAA, 1'b1);
      chk(flag, 1'b1);
      wr(8'h5C, 1'b1);
      chk(rxd, 8'h5C);
      chk(rxv, 1'b1);
      itb_master_inst.start();
      wr(8'hF5, 1'b1);
      chk(txm, 1'b1);
      itb_master_inst.xfer(8'hFF, 1'b0, a, r);
      chk(r, 8'hC3);
      itb_master_inst.stop();
      chk(flag, 1'b0);
      itb_master_inst.start();
      wr(8'hF5, 1'b0);
      chk(dones[11:0], 12'h005);
      itb_master_inst.stop();
      // wrong second byte, then wrong high bits in the first
      itb_master_inst.start();
      wr(8'hF4, 1'b1);
      wr(8'hAB, 1'b0);
      chk(flag, 1'b0);
      itb_master_inst.start();
      wr(8'hF6, 1'b0);
      itb_master_inst.stop();
      // restart with another address drops the selection
      itb_master_inst.start();
      wr(8'hF4, 1'b1);
      wr(8'hAA, 1'b1);
      itb_master_inst.start();
      wr(8'hF6, 1'b0);
      chk(flag, 1'b0);
      itb_master_inst.stop();
      // disable in mid-selection forgets the match
      itb_master_inst.start();
      wr(8'hF4, 1'b1);
      wr(8'hAA, 1'b1);
      en = 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1;
      en = 1'b1;
      chk(flag, 1'b0);
      itb_master_inst.start();
      wr(8'hF5, 1'b0);
      itb_master_inst.stop();
      // 7-bit matching with extension off
      ext = 1'b0;
      own = 7'h78;
      itb_master_inst.start();
      wr(8'hF0, 1'b0);
      itb_master_inst.stop();
      own = 7'h2A;
      itb_master_inst.start();
      wr(8'h54, 1'b1);
      chk(flag, 1'b1);
      itb_master_inst.stop();
      rate(6'h15, 12'h058, 12'h011, 12'h026);
      rate(6'h17, 12'h080, 12'h015, 12'h03A);
      rate(6'h1F, 12'h0F0, 12'h021, 12'h076);
      rate(6'h3B, 12'h800, 12'h101, 12'h3FE);
      rate(6'h3F, 12'hF00, 12'h201, 12'h77E);
      summarize();
   end
endmodule : test_itb_target
